/* File: vdrs_pkg.sv */
/*
 * Shared constants of the reference sequencer: clock rates, code tables, modes.
 * Assumes a 40 MHz core clock.
 */
package vdrs_pkg;
  // ----------------------------------------
  // clock rates in kHz
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned SAMPLE_KHZ = 5500;
  localparam int unsigned SLEW_KHZ = 345;
  localparam int ACC_W = 16;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_SAMPLE_INC = ACC_W'(SAMPLE_KHZ);
  localparam logic [ACC_W-1:0] ACC_SLEW_INC = ACC_W'(SLEW_KHZ);

  // ----------------------------------------
  // code filtering
  // ----------------------------------------
  localparam int CODE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] STABLE_CNT = 3'h3;
  localparam logic [CNT_W-1:0] OFF_CNT = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

  // ----------------------------------------
  // tables (reference in 6.25 mV units)
  // ----------------------------------------
  localparam logic [CODE_W-1:0] OFF5_CODE = 8'h1f;
  localparam logic [CODE_W-1:0] MASK5 = 8'h1f;
  localparam logic [CODE_W-1:0] MASK6 = 8'h3f;
  localparam logic [CODE_W-1:0] LOW6_BASE = 8'h20;
  localparam logic [CODE_W-1:0] HI_TOP_REF = 8'hf8;
  localparam logic [CODE_W-1:0] LO_TOP_REF = 8'h7a;
  localparam logic [CODE_W-1:0] REF_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] REF_STEP = 8'h01;

  typedef enum logic [1:0] {
    VDRS_MODE_STEP8 = 2'b00,
    VDRS_MODE_TAB5 = 2'b01,
    VDRS_MODE_TAB6 = 2'b10
  } vdrs_mode_t;
endpackage

/* File: vdrs_code_if.sv */
/*
 * Carrier for the filtered code between the filter and the sequencer core.
 * Assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface vdrs_code_if;
  logic [vdrs_pkg::CODE_W-1:0] code;
  logic [vdrs_pkg::CNT_W-1:0] count;
  logic tick;

  modport filt (output code, output count, output tick);
  modport core (input code, input count, input tick);
endinterface

/* File: vdrs_code_filter.sv */
/*
 * Synchronises the code lines, samples them at 5.5 MHz and counts equal readings.
 * Assumes asynchronous code pins and a 40 MHz clock.
 */
`timescale 1ns/1ps
module vdrs_code_filter (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // code pins
  input wire logic [vdrs_pkg::CODE_W-1:0] voltage_id_code_i,
  // filtered code
  vdrs_code_if.filt cf
);
  logic [vdrs_pkg::CODE_W-1:0] sync1_reg;
  logic [vdrs_pkg::CODE_W-1:0] sync2_reg;
  logic [vdrs_pkg::ACC_W-1:0] acc_reg;
  logic [vdrs_pkg::ACC_W-1:0] acc_next;
  logic wrap;

  // ----------------------------------------
  // two-flop synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= voltage_id_code_i;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // 5.5 MHz sampling tick
  // ----------------------------------------
  // phase accumulator gives the exact mean rate; jitter is one core cycle
  assign acc_next = acc_reg + vdrs_pkg::ACC_SAMPLE_INC;
  assign wrap = (acc_next >= vdrs_pkg::ACC_MOD);

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_reg <= '0;
      cf.tick <= 1'b0;
    end
    else
    begin
      acc_reg <= wrap ? acc_next - vdrs_pkg::ACC_MOD : acc_next;
      cf.tick <= wrap;
    end
  end

  // ----------------------------------------
  // equal-reading counter
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cf.code <= '0;
      cf.count <= '0;
    end
    else if (wrap)
    begin
      cf.code <= sync2_reg;
      if (sync2_reg != cf.code)
        cf.count <= vdrs_pkg::CNT_ONE;
      else if (cf.count < vdrs_pkg::OFF_CNT)
        cf.count <= cf.count + vdrs_pkg::CNT_ONE;
    end
  end
endmodule

/* File: vdrs_top.sv */
/*
 * Reference sequencer: validates code changes, steps or slews the reference,
 * latches off on off codes and gates the power switch drives.
 * Assumes pwm demands from the modulator on mclk_i; en_i and codes are async.
 */
`timescale 1ns/1ps
module vdrs_top #(
  // arbitrary default; off code of the stepped table
  parameter logic [vdrs_pkg::CODE_W-1:0] OFF8_CODE = 8'h00
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // processor side
  input wire logic [vdrs_pkg::CODE_W-1:0] voltage_id_code_i,
  input wire logic [1:0] mode_i,
  input wire logic en_i,
  // modulator demands
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  // outputs
  output logic [vdrs_pkg::CODE_W-1:0] ref_code_o,
  output logic high_side_gate_drive_o,
  output logic low_side_gate_drive_o,
  output logic running_o,
  output logic off_latched_o
);
  vdrs_code_if cf ();
  vdrs_pkg::vdrs_mode_t mode;
  logic en1_reg;
  logic en2_reg;
  logic [vdrs_pkg::CODE_W-1:0] target_reg;
  logic [vdrs_pkg::CODE_W-1:0] ref_reg;
  logic [vdrs_pkg::CODE_W-1:0] ref_next;
  logic [vdrs_pkg::ACC_W-1:0] slew_acc_reg;
  logic [vdrs_pkg::ACC_W-1:0] slew_sum;
  logic slew_tick;
  logic off_reg;
  logic run_reg;
  logic is_off;
  logic blocked;
  logic [1:0] mode1_reg;
  logic [1:0] mode2_reg;
  logic target_load;
  logic [vdrs_pkg::CODE_W-1:0] target_next;

  // strap is a pin like the others; it settles once, so two flops suffice
  assign mode = vdrs_pkg::vdrs_mode_t'(mode2_reg);

  // ----------------------------------------
  // code to reference conversion
  // ----------------------------------------
  function automatic logic [vdrs_pkg::CODE_W-1:0] code_to_ref(
    input vdrs_pkg::vdrs_mode_t m,
    input logic [vdrs_pkg::CODE_W-1:0] c
  );
    logic [vdrs_pkg::CODE_W-1:0] k;
    k = c & ((m == vdrs_pkg::VDRS_MODE_TAB5) ? vdrs_pkg::MASK5 : vdrs_pkg::MASK6);
    if (m == vdrs_pkg::VDRS_MODE_STEP8)
      return c;
    else if (k < vdrs_pkg::LOW6_BASE)
      return vdrs_pkg::HI_TOP_REF - {k[5:0], 2'b00};
    else
      return vdrs_pkg::LO_TOP_REF - {k[6:0], 1'b0} + {vdrs_pkg::LOW6_BASE[6:0], 1'b0};
  endfunction

  function automatic logic is_off_code(
    input vdrs_pkg::vdrs_mode_t m,
    input logic [vdrs_pkg::CODE_W-1:0] c
  );
    unique case (m)
      vdrs_pkg::VDRS_MODE_STEP8: return c == OFF8_CODE;
      vdrs_pkg::VDRS_MODE_TAB5: return (c & vdrs_pkg::MASK5) == vdrs_pkg::OFF5_CODE;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // code filter
  // ----------------------------------------
  vdrs_code_filter u_filter (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .voltage_id_code_i(voltage_id_code_i),
    .cf(cf)
  );

  // ----------------------------------------
  // enable synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      en1_reg <= 1'b0;
      en2_reg <= 1'b0;
    end
    else
    begin
      en1_reg <= en_i;
      en2_reg <= en1_reg;
    end
  end

  // ----------------------------------------
  // mode strap synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode1_reg <= '0;
      mode2_reg <= '0;
    end
    else
    begin
      mode1_reg <= mode_i;
      mode2_reg <= mode1_reg;
    end
  end

  // ----------------------------------------
  // off latch and run state
  // ----------------------------------------
  assign is_off = is_off_code(mode, cf.code);
  assign blocked = (mode == vdrs_pkg::VDRS_MODE_TAB5) && is_off
                   && (cf.count >= vdrs_pkg::STABLE_CNT);

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      off_reg <= 1'b0;
    else if (!en2_reg)
      off_reg <= 1'b0;
    else if (run_reg && is_off && cf.count >= vdrs_pkg::OFF_CNT)
      off_reg <= 1'b1;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      run_reg <= 1'b0;
    else if (!en2_reg || off_reg)
      run_reg <= 1'b0;
    else if (!run_reg && !blocked && cf.count >= vdrs_pkg::STABLE_CNT)
      run_reg <= 1'b1;
  end

  // ----------------------------------------
  // target acceptance
  // ----------------------------------------
  // off codes never become a target; the reference holds instead
  assign target_load = (cf.count >= vdrs_pkg::STABLE_CNT) && !is_off;
  assign target_next = target_load ? code_to_ref(mode, cf.code) : target_reg;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      target_reg <= vdrs_pkg::REF_ZERO;
    else
      target_reg <= target_next;
  end

  // ----------------------------------------
  // 345 kHz slew tick
  // ----------------------------------------
  assign slew_sum = slew_acc_reg + vdrs_pkg::ACC_SLEW_INC;
  assign slew_tick = (slew_sum >= vdrs_pkg::ACC_MOD);

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      slew_acc_reg <= '0;
    else
      slew_acc_reg <= slew_tick ? slew_sum - vdrs_pkg::ACC_MOD : slew_sum;
  end

  // ----------------------------------------
  // reference movement
  // ----------------------------------------
  always_comb
  begin
    ref_next = ref_reg;
    // while stopped, follow the target loaded on this same edge, so that a
    // start never opens with a ramp from the previous level
    if (!run_reg)
      ref_next = target_next;
    else if (mode == vdrs_pkg::VDRS_MODE_STEP8)
    begin
      // a one-step change lands within one tick, i.e. directly
      if (cf.tick && target_reg > ref_reg)
        ref_next = ref_reg + vdrs_pkg::REF_STEP;
      else if (cf.tick && target_reg < ref_reg)
        ref_next = ref_reg - vdrs_pkg::REF_STEP;
    end
    else if (slew_tick && target_reg > ref_reg)
      ref_next = ref_reg + vdrs_pkg::REF_STEP;
    else if (slew_tick && target_reg < ref_reg)
      ref_next = ref_reg - vdrs_pkg::REF_STEP;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ref_reg <= vdrs_pkg::REF_ZERO;
    else
      ref_reg <= ref_next;
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // both drives forced low when not running, and never both high
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_code_o <= vdrs_pkg::REF_ZERO;
      high_side_gate_drive_o <= 1'b0;
      low_side_gate_drive_o <= 1'b0;
      running_o <= 1'b0;
      off_latched_o <= 1'b0;
    end
    else
    begin
      ref_code_o <= ref_reg;
      high_side_gate_drive_o <= run_reg && pwm_high_i;
      low_side_gate_drive_o <= run_reg && pwm_low_i && !pwm_high_i;
      running_o <= run_reg;
      off_latched_o <= off_reg;
    end
  end
endmodule

/* File: vdrs_properties.sv */
/* Port checker for vdrs_top.
   Assumes it is bound onto vdrs_top. */
`timescale 1ns/1ps
module vdrs_chk (
  // clock, reset, inputs
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  input wire logic [1:0] mode_i,
  // outputs
  input wire logic [vdrs_pkg::CODE_W-1:0] ref_code_o,
  input wire logic high_side_gate_drive_o,
  input wire logic low_side_gate_drive_o,
  input wire logic running_o,
  input wire logic off_latched_o
);
  // ----
  // helpers
  // ----
  logic [1:0] run_reg;
  logic [7:0] ref_reg;
  logic [7:0] gap_reg;
  logic stdy;
  logic chg;
  // first run cycles skipped: ref_code_o trails the start
  assign stdy = running_o && run_reg == 2'b11;
  assign chg = ref_code_o != ref_reg;
  always_ff @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      run_reg <= 2'b00;
      ref_reg <= 8'h00;
    end
    else
    begin
      run_reg <= {run_reg[0], running_o};
      ref_reg <= ref_code_o;
    end
  // cycles since the last step, saturating
  always_ff @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
      gap_reg <= 8'hff;
    else if (!stdy)
      gap_reg <= 8'hff;
    else if (chg)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hff)
      gap_reg <= gap_reg + 8'h01;
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_gate_idle:
    assert property (!running_o && !$past(running_o) |-> !high_side_gate_drive_o
      && !low_side_gate_drive_o) else $error("gate on while stopped");
  chk_no_overlap:
    assert property (!(high_side_gate_drive_o && low_side_gate_drive_o))
      else $error("both gates on");
  chk_gate_follow:
    assert property (running_o && $past(running_o) |-> high_side_gate_drive_o ==
      $past(pwm_high_i) && low_side_gate_drive_o == $past(pwm_low_i && !pwm_high_i))
      else $error("gate not following demand");
  chk_off_stops:
    assert property (off_latched_o |=> !running_o) else $error("running while off");
  chk_latch_holds:
    assert property (off_latched_o && en_i && $past(en_i) && $past(en_i, 2)
      && $past(en_i, 3) |=> off_latched_o) else $error("off latch lost");
  chk_ref_unit:
    assert property (stdy |-> ref_code_o - ref_reg inside {8'h00, 8'h01, 8'hff})
      else $error("reference moved over one unit");
  chk_step_rate:
    assert property (stdy && chg && mode_i == 2'b00 |-> gap_reg >= 8'h05)
      else $error("steps faster than sampling");
  chk_slew_rate:
    assert property (stdy && chg && mode_i != 2'b00 |-> gap_reg >= 8'h6e)
      else $error("slew faster than slew tick");
  cov_step: cover property (stdy && chg && mode_i == 2'b00);
  cov_slew: cover property (stdy && chg && mode_i == 2'b01);
  cov_latch: cover property ($rose(off_latched_o));
endmodule
bind vdrs_top vdrs_chk i_vdrs_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(en_i),
  .pwm_high_i(pwm_high_i), .pwm_low_i(pwm_low_i), .mode_i(mode_i),
  .ref_code_o(ref_code_o), .high_side_gate_drive_o(high_side_gate_drive_o),
  .low_side_gate_drive_o(low_side_gate_drive_o), .running_o(running_o),
  .off_latched_o(off_latched_o));

/* File: vdrs_proc.sv */
/* Processor model driving the code lines.
   Assumes tasks are entered just after a clock edge. */
`timescale 1ns/1ps
module vdrs_proc (
  // clock
  input wire logic mclk_i,
  // code lines
  output logic [vdrs_pkg::CODE_W-1:0] code_o
);
  // ----
  // code driving
  // ----
  initial code_o = 8'h00;
  // large jumps are legal only in the table modes
  task automatic put(input logic [7:0] c, input int n);
    @(posedge mclk_i);
    code_o <= c;
    repeat (n) @(posedge mclk_i);
  endtask
  // stepped table: one unit per change, 1.1 us apart
  task automatic walk(input logic [7:0] c);
    while (code_o != c)
      put(code_o < c ? code_o + 8'h01 : code_o - 8'h01, 44);
  endtask
endmodule

/* File: tb_vid_dac_reference_sequencer.sv */
/* Bench for vdrs_top.
   Assumes vdrs_proc drives the code lines. */
`timescale 1ns/1ps
module tb_vid_dac_reference_sequencer;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic en_i = 1'b0;
  logic [1:0] mode_i = 2'b00;
  logic [2:0] pwm_reg = 3'h0;
  logic [7:0] code, rc;
  logic hs, ls, run, offl;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // ----
  // harness
  // ----
  always #12.5 mclk_i = ~mclk_i;
  // demands overlap on purpose
  always @(posedge mclk_i)
  begin
    pwm_reg <= pwm_reg + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      print_verdict();
    end
  end
  vdrs_proc p (.mclk_i(mclk_i), .code_o(code));
  vdrs_top #(.OFF8_CODE(8'h00)) i_vdrs_top (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .voltage_id_code_i(code), .mode_i(mode_i), .en_i(en_i), .pwm_high_i(pwm_reg[2]),
    .pwm_low_i(pwm_reg[1]), .ref_code_o(rc), .high_side_gate_drive_o(hs),
    .low_side_gate_drive_o(ls), .running_o(run), .off_latched_o(offl));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wref(input logic [7:0] e, input int n);
    for (int i = 0; i < n && rc !== e; i++)
      @(posedge mclk_i);
    cmp("ref", e, rc);
  endtask
  // drop enable, pick table, then wait for the start
  task automatic go(input logic [1:0] m, input logic [7:0] c);
    en_i <= 1'b0;
    mode_i <= m;
    p.put(c, 8);
    en_i <= 1'b1;
    for (int i = 0; i < 200 && run !== 1'b1; i++)
      @(posedge mclk_i);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_step8;
    go(2'b00, 8'h40);
    cmp("run", 8'h01, 8'(run));
    wref(8'h40, 20);
    p.put(8'h41, 10);
    cmp("early", 8'h40, rc);
    wref(8'h41, 40);
    p.walk(8'h44);
    wref(8'h44, 40);
    p.put(8'h48, 0);
    wref(8'h48, 80);
    $display("test step8 done");
  endtask
  task automatic t_off8;
    p.put(8'h00, 10);
    p.put(8'h48, 40);
    cmp("latch", 8'h00, 8'(offl));
    p.put(8'h00, 60);
    cmp("latch", 8'h01, 8'(offl));
    cmp("gates", 8'h00, {6'h00, hs, ls});
    p.put(8'h48, 60);
    cmp("held", 8'h02, {6'h00, offl, run});
    go(2'b00, 8'h48);
    cmp("restart", 8'h01, {6'h00, offl, run});
    $display("test off8 done");
  endtask
  task automatic t_tab5;
    go(2'b01, 8'h1f);
    cmp("blocked", 8'h00, 8'(run));
    p.put(8'h10, 0);
    wref(8'hb8, 200);
    p.put(8'h0e, 400);
    cmp("slewing", 8'h00, 8'(rc == 8'hc0));
    wref(8'hc0, 800);
    p.put(8'h1f, 60);
    cmp("off5", 8'h01, 8'(offl));
    $display("test tab5 done");
  endtask
  task automatic t_tab6;
    go(2'b10, 8'h1f);
    cmp("run", 8'h01, 8'(run));
    wref(8'h7c, 50);
    p.put(8'h20, 0);
    wref(8'h7a, 400);
    // spare strap code reads the six-bit table and has no off code
    go(2'b11, 8'h1f);
    cmp("run3", 8'h01, 8'(run));
    wref(8'h7c, 50);
    p.put(8'h1f, 40);
    cmp("off3", 8'h01, {6'h00, offl, run});
    $display("test tab6 done");
  endtask
  initial
  begin
    repeat (15) @(posedge mclk_i);
    cmp("reset", 8'h00, rc | {4'h0, hs, ls, run, offl});
    @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_step8();
    t_off8();
    t_tab5();
    t_tab6();
    print_verdict();
  end
endmodule
